// ===== hdl/tatm_params.svh
// register map, reset values and timing constants of the throttle monitor
`ifndef TATM_PARAMS_SVH
`define TATM_PARAMS_SVH

`define TATM_ADDR_CONFIG3 8'h02
`define TATM_ADDR_TIMER 8'h0f
`define TATM_ADDR_STATUS1 8'h10
`define TATM_ADDR_STATUS2 8'h11
`define TATM_ADDR_MASK1 8'h12
`define TATM_ADDR_MASK2 8'h13
`define TATM_ADDR_TLIMIT 8'h1e
`define TATM_ADDR_CRIT_TA 8'h1f
`define TATM_ADDR_CRIT_TB 8'h20
`define TATM_ADDR_CRIT_EXT 8'h21
`define TATM_ADDR_CRIT_INT 8'h22

`define TATM_RST_CONFIG3 8'h00
`define TATM_RST_MASK 8'h00
`define TATM_RST_TLIMIT 8'h00
`define TATM_RST_CRIT 8'h64

`define TATM_PIN_MODE_LSB 0
`define TATM_PIN_MODE_W 2
`define TATM_PIN_MODE_CRIT 2'h1

`define TATM_S1_SUMMARY 7
`define TATM_S2_THROTTLE 1
`define TATM_S2_OVERTEMP 0

`define TATM_TIMER_FIRST 8'h01
`define TATM_TIMER_COARSE 8'h02
`define TATM_TIMER_FULL 8'hff

`define TATM_CLK_HZ 50000000
`define TATM_FINE_STEP_US 50000
`define TATM_COARSE_STEP_US 22760
`define TATM_US_PER_S 1000000

`endif

// ===== hdl/tatm_pkg.sv
// shared types of the throttle monitor
package tatm_pkg;

  typedef enum logic [1:0] {
    TATM_PH_IDLE = 2'b00,
    TATM_PH_FINE = 2'b01,
    TATM_PH_COARSE = 2'b10
  } tatm_phase_t;

  typedef logic [7:0] tatm_byte_t;

endpackage : tatm_pkg

// ===== hdl/tatm_sync2.sv
// two-flop synchroniser, also used as the reset release stage
`timescale 1ns/1ps
module tatm_sync2
  import tatm_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic d_in,
  output logic q_out
);

  typedef struct packed {
    logic meta;
    logic stable;
  } tatm_sync_t;

  tatm_sync_t s_q;
  tatm_sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = d_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{meta: RESET_VAL, stable: RESET_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.stable;
endmodule : tatm_sync2

// ===== hdl/tatm_throttle_timer.sv
// cumulative saturating throttle assertion timer, cleared on read
`timescale 1ns/1ps
`include "tatm_params.svh"
module tatm_throttle_timer
  import tatm_pkg::*;
#(
  parameter int unsigned FINE_CYCLES =
    `TATM_CLK_HZ / `TATM_US_PER_S * `TATM_FINE_STEP_US,
  parameter int unsigned COARSE_CYCLES =
    `TATM_CLK_HZ / `TATM_US_PER_S * `TATM_COARSE_STEP_US,
  parameter int unsigned PRE_W = 22
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic active_in,
  input wire logic clear_in,
  output tatm_byte_t value_out
);

  typedef struct packed {
    tatm_phase_t phase;
    logic [PRE_W-1:0] pre;
    tatm_byte_t value;
  } tatm_tmr_t;

  tatm_tmr_t t_q;
  tatm_tmr_t t_d;

  localparam logic [PRE_W-1:0] FINE_LAST = PRE_W'(FINE_CYCLES - 1);
  localparam logic [PRE_W-1:0] COARSE_LAST = PRE_W'(COARSE_CYCLES - 1);

  always_comb begin
    t_d = t_q;
    if (clear_in) begin
      // a read during assertion restarts the count with bit 0 set
      t_d.value = active_in ? `TATM_TIMER_FIRST : '0;
      t_d.phase = active_in ? TATM_PH_FINE : TATM_PH_IDLE;
      t_d.pre = '0;
    end else if (active_in) begin
      case (t_q.phase)
        TATM_PH_IDLE: begin
          t_d.value = `TATM_TIMER_FIRST;
          t_d.phase = TATM_PH_FINE;
          t_d.pre = '0;
        end
        TATM_PH_FINE: begin
          if (t_q.pre == FINE_LAST) begin
            t_d.value = `TATM_TIMER_COARSE;
            t_d.phase = TATM_PH_COARSE;
            t_d.pre = '0;
          end else begin
            t_d.pre = t_q.pre + 1'b1;
          end
        end
        TATM_PH_COARSE: begin
          if (t_q.value == `TATM_TIMER_FULL) begin
            t_d.pre = '0;
          end else if (t_q.pre == COARSE_LAST) begin
            t_d.value = t_q.value + 8'h01;
            t_d.pre = '0;
          end else begin
            t_d.pre = t_q.pre + 1'b1;
          end
        end
        default: begin
          t_d.phase = TATM_PH_IDLE;
        end
      endcase
    end
    // negation simply pauses: value and prescaler hold
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      t_q <= '{phase: TATM_PH_IDLE, pre: '0, value: '0};
    end else begin
      t_q <= t_d;
    end
  end

  assign value_out = t_q.value;
endmodule : tatm_throttle_timer

// ===== hdl/tatm_top.sv
// throttle monitor: alert masking, assertion timer, critical temp pin
// Summary of operation
// - mask registers live at 0x12 and 0x13
// - masks gate alert only, status still sets
// - mask1 bit7 summary, bits 6..0 sources
// - mask2 bits 5..0 faults, throttle, overtemp
// - timer runs only while input asserted
// - timer saturates at full scale until read
// - bit0 on first assertion, bit1 after 50ms
// - coarse step weight is 22.76 ms
// - timer read clears timer and throttle flag
// - read during assertion restarts at one
// - timer above limit sets flag and alert
// - limit zero first assertion, one 50ms
// - limit spans zero to 5.8 seconds
// - config3 bits 1:0 = 01 selects output
// - crit output low above limit until below
// - crit held at least one monitor cycle
// - four crit limits at 0x1f..0x22
// - status sticky, read clears once condition gone
// - alert low while unmasked status set
// - status1 bit7 summarises status2
`timescale 1ns/1ps
`include "tatm_params.svh"
module tatm_top
  import tatm_pkg::*;
#(
  parameter int unsigned FINE_CYCLES =
    `TATM_CLK_HZ / `TATM_US_PER_S * `TATM_FINE_STEP_US,
  parameter int unsigned COARSE_CYCLES =
    `TATM_CLK_HZ / `TATM_US_PER_S * `TATM_COARSE_STEP_US,
  parameter int unsigned N_SRC1 = 7,
  parameter int unsigned N_FAULT = 4,
  parameter int unsigned N_CRIT = 4,
  parameter int unsigned TEMP_W = 10
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic cpu_throttle_n_in,
  input wire logic [N_SRC1-1:0] src_out_of_limit_in,
  input wire logic [N_FAULT-1:0] src_fault_in,
  input wire logic [N_CRIT-1:0] crit_chan_en_in,
  input wire logic [N_CRIT-1:0] meas_valid_in,
  input wire logic [N_CRIT*TEMP_W-1:0] meas_temp_in,
  output logic [7:0] reg_rdata_out,
  output logic alert_n_out,
  output logic crit_temp_n_out,
  output logic crit_temp_oe_n_out
);

  typedef struct packed {
    tatm_byte_t config3;
    tatm_byte_t alert_mask_primary;
    tatm_byte_t alert_mask_secondary;
    tatm_byte_t throttle_time_limit;
    logic [N_CRIT-1:0][7:0] crit_limit;
    logic [N_SRC1-1:0] status1;
    logic [5:0] status2;
    logic [N_CRIT-1:0] crit_hot;
    tatm_byte_t rdata;
    logic alert_n;
    logic crit_n;
    logic crit_oe_n;
  } tatm_state_t;

  tatm_state_t s_q;
  tatm_state_t s_d;

  logic rst_n_sync;
  logic throttle_n_sync;
  logic pin_is_output;
  logic throttle_active;
  logic timer_clear;
  tatm_byte_t timer_value;
  logic throttle_over;
  logic restart_over;
  logic overtemp_now;
  logic [5:0] status2_src;
  tatm_byte_t status1_view;
  tatm_byte_t status2_view;

  // temperature has two fraction bits, so a quarter degree above the
  // integer limit is the first code that is strictly greater
  function automatic logic over_limit(
    input logic [TEMP_W-1:0] temp,
    input tatm_byte_t limit
  );
    over_limit = temp > {limit, 2'b00};
  endfunction : over_limit

  function automatic logic [7:0] sticky(
    input logic [7:0] cur,
    input logic [7:0] src,
    input logic clr
  );
    // a live condition wins over the clearing read
    sticky = clr ? src : (cur | src);
  endfunction : sticky

  function automatic logic strobe_hit(
    input logic strobe,
    input tatm_byte_t addr,
    input tatm_byte_t target
  );
    strobe_hit = strobe && addr == target;
  endfunction : strobe_hit

  tatm_sync2 #(
    .RESET_VAL(1'b0)
  ) u_rst_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in(1'b1),
    .q_out(rst_n_sync)
  );

  // input idles high so reset looks like no assertion
  tatm_sync2 #(
    .RESET_VAL(1'b1)
  ) u_throttle_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_sync),
    .d_in(cpu_throttle_n_in),
    .q_out(throttle_n_sync)
  );

  assign pin_is_output = s_q.config3[`TATM_PIN_MODE_LSB +:
    `TATM_PIN_MODE_W] == `TATM_PIN_MODE_CRIT;
  // while the pin drives out its own level must not feed the timer
  assign throttle_active = !throttle_n_sync && !pin_is_output;
  assign timer_clear = strobe_hit(reg_rd_in, reg_addr_in,
    `TATM_ADDR_TIMER);

  tatm_throttle_timer #(
    .FINE_CYCLES(FINE_CYCLES),
    .COARSE_CYCLES(COARSE_CYCLES),
    .PRE_W(22)
  ) u_timer (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_sync),
    .active_in(throttle_active),
    .clear_in(timer_clear),
    .value_out(timer_value)
  );

  // full 8-bit limit range: zero trips on the first assertion
  assign throttle_over =
    timer_value > s_q.throttle_time_limit;
  // a read restarts the timer, so judge the flag by the restart value
  assign restart_over = throttle_active &&
    `TATM_TIMER_FIRST > s_q.throttle_time_limit;
  assign overtemp_now = |s_q.crit_hot;
  assign status2_src = {src_fault_in, throttle_over, overtemp_now};
  assign status1_view = {|s_q.status2, s_q.status1};
  assign status2_view = {2'b00, s_q.status2};

  always_comb begin
    logic rd1;
    logic rd2;
    logic any1;
    logic any2;
    rd1 = 1'b0;
    rd2 = 1'b0;
    any1 = 1'b0;
    any2 = 1'b0;
    s_d = s_q;
    rd1 = strobe_hit(reg_rd_in, reg_addr_in, `TATM_ADDR_STATUS1);
    rd2 = strobe_hit(reg_rd_in, reg_addr_in, `TATM_ADDR_STATUS2);

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        `TATM_ADDR_CONFIG3: s_d.config3 = reg_wdata_in;
        `TATM_ADDR_MASK1: s_d.alert_mask_primary = reg_wdata_in;
        `TATM_ADDR_MASK2: s_d.alert_mask_secondary = reg_wdata_in;
        `TATM_ADDR_TLIMIT: s_d.throttle_time_limit = reg_wdata_in;
        `TATM_ADDR_CRIT_TA: s_d.crit_limit[0] = reg_wdata_in;
        `TATM_ADDR_CRIT_TB: s_d.crit_limit[1] = reg_wdata_in;
        `TATM_ADDR_CRIT_EXT: s_d.crit_limit[2] = reg_wdata_in;
        `TATM_ADDR_CRIT_INT: s_d.crit_limit[3] = reg_wdata_in;
        default: begin
        end
      endcase
    end

    // register reads, data one cycle after the strobe
    if (reg_rd_in) begin
      case (reg_addr_in)
        `TATM_ADDR_CONFIG3: s_d.rdata = s_q.config3;
        `TATM_ADDR_TIMER: s_d.rdata = timer_value;
        `TATM_ADDR_STATUS1: s_d.rdata = status1_view;
        `TATM_ADDR_STATUS2: s_d.rdata = status2_view;
        `TATM_ADDR_MASK1: s_d.rdata = s_q.alert_mask_primary;
        `TATM_ADDR_MASK2: s_d.rdata = s_q.alert_mask_secondary;
        `TATM_ADDR_TLIMIT: s_d.rdata = s_q.throttle_time_limit;
        `TATM_ADDR_CRIT_TA: s_d.rdata = s_q.crit_limit[0];
        `TATM_ADDR_CRIT_TB: s_d.rdata = s_q.crit_limit[1];
        `TATM_ADDR_CRIT_EXT: s_d.rdata = s_q.crit_limit[2];
        `TATM_ADDR_CRIT_INT: s_d.rdata = s_q.crit_limit[3];
        default: s_d.rdata = 8'h00;
      endcase
    end

    // sticky status capture regardless of masks
    s_d.status1 = N_SRC1'(sticky(8'(s_q.status1),
      8'(src_out_of_limit_in), rd1));
    s_d.status2 = 6'(sticky(8'(s_q.status2), 8'(status2_src), rd2));
    if (timer_clear && !restart_over) begin
      // timer read drops the throttle flag unless the restart value trips
      s_d.status2[`TATM_S2_THROTTLE] = 1'b0;
    end

    // critical channels re-evaluated only on their own measurement
    for (int i = 0; i < N_CRIT; i++) begin
      if (meas_valid_in[i]) begin
        s_d.crit_hot[i] = crit_chan_en_in[i] &&
          over_limit(meas_temp_in[i*TEMP_W +: TEMP_W],
            s_q.crit_limit[i]);
      end
    end

    // alert from unmasked sticky bits
    any1 = |(s_d.status1 & ~s_q.alert_mask_primary[N_SRC1-1:0]);
    any2 = |(s_d.status2 & ~s_q.alert_mask_secondary[5:0]) &&
      !s_q.alert_mask_primary[`TATM_S1_SUMMARY];
    s_d.alert_n = !(any1 || any2);

    // shared pin: drive low only in output mode
    s_d.crit_oe_n = !pin_is_output;
    s_d.crit_n = !(pin_is_output && |s_d.crit_hot);
  end

  always_ff @(posedge mclk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_q.config3 <= `TATM_RST_CONFIG3;
      s_q.alert_mask_primary <= `TATM_RST_MASK;
      s_q.alert_mask_secondary <= `TATM_RST_MASK;
      s_q.throttle_time_limit <= `TATM_RST_TLIMIT;
      s_q.crit_limit <= {N_CRIT{`TATM_RST_CRIT}};
      s_q.status1 <= '0;
      s_q.status2 <= '0;
      s_q.crit_hot <= '0;
      s_q.rdata <= 8'h00;
      s_q.alert_n <= 1'b1;
      s_q.crit_n <= 1'b1;
      s_q.crit_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign alert_n_out = s_q.alert_n;
  assign crit_temp_n_out = s_q.crit_n;
  assign crit_temp_oe_n_out = s_q.crit_oe_n;

endmodule : tatm_top

// ===== tb/tatm_top_assertions.sv
// port-level assertion checker for the throttle monitor
`timescale 1ns/1ps
module tatm_top_chk #(
  parameter int unsigned N_SRC1 = 7,
  parameter int unsigned N_CRIT = 4,
  parameter int unsigned TEMP_W = 10
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic cpu_throttle_n_in,
  input wire logic [N_SRC1-1:0] src_out_of_limit_in,
  input wire logic [N_CRIT-1:0] crit_chan_en_in,
  input wire logic [N_CRIT-1:0] meas_valid_in,
  input wire logic [N_CRIT*TEMP_W-1:0] meas_temp_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic alert_n_out,
  input wire logic crit_temp_n_out,
  input wire logic crit_temp_oe_n_out
);
  logic [7:0] m1_q;
  logic [7:0] m2_q;
  logic [7:0] lim_q;
  logic mode_q;
  wire logic rd_t = reg_rd_in && reg_addr_in == 8'h0f;
  wire logic all_masked = m1_q == 8'hff && m2_q[5:0] == 6'h3f;
  wire logic [TEMP_W-1:0] t3 = meas_temp_in[N_CRIT*TEMP_W-1 -: TEMP_W];

  // shadow of the writable fields the port checks depend on
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      m1_q <= 8'h00;
      m2_q <= 8'h00;
      lim_q <= 8'h64;
      mode_q <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == 8'h12) m1_q <= reg_wdata_in;
      if (reg_addr_in == 8'h13) m2_q <= reg_wdata_in;
      if (reg_addr_in == 8'h22) lim_q <= reg_wdata_in;
      if (reg_addr_in == 8'h02) mode_q <= reg_wdata_in[1:0] == 2'h1;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  AST_MASK_RDBACK: assert property (reg_rd_in && reg_addr_in == 8'h12
    |=> reg_rdata_out == $past(m1_q)) else $error("mask readback");
  AST_ALERT_MASKED: assert property (all_masked[*3] |-> alert_n_out)
    else $error("alert while all masked");
  AST_ALERT_SRC: assert property (
    (src_out_of_limit_in[0] && !m1_q[0])[*3] |-> !alert_n_out)
    else $error("alert missing");
  AST_OE_MODE: assert property (mode_q == $past(mode_q)
    |-> crit_temp_oe_n_out == !mode_q) else $error("pin enable");
  AST_CRIT_IDLE: assert property (!mode_q && !$past(mode_q)
    |-> crit_temp_n_out) else $error("crit pin outside mode");
  AST_CRIT_TRIP: assert property (mode_q && $past(mode_q)
    && meas_valid_in[N_CRIT-1] && crit_chan_en_in[N_CRIT-1]
    && t3 > {lim_q, 2'b00} |-> ##2 !crit_temp_n_out)
    else $error("crit trip missing");
  AST_CRIT_HOLD: assert property (
    $rose(crit_temp_n_out) && mode_q && $past(mode_q, 3)
    |-> $past(meas_valid_in) != 0 || $past(meas_valid_in, 2) != 0)
    else $error("crit released without measurement");
  AST_TIMER_CLEAR: assert property (
    (cpu_throttle_n_in[*5] ##0 rd_t) ##1 cpu_throttle_n_in
    ##1 (rd_t && cpu_throttle_n_in) |=> reg_rdata_out == 8'h00)
    else $error("timer not cleared by read");
endmodule : tatm_top_chk

bind tatm_top tatm_top_chk #(.N_SRC1(N_SRC1), .N_CRIT(N_CRIT),
  .TEMP_W(TEMP_W)) i_tatm_top_chk (.mclk_in, .rst_n_in, .reg_addr_in,
  .reg_wr_in, .reg_rd_in, .reg_wdata_in, .cpu_throttle_n_in,
  .src_out_of_limit_in, .crit_chan_en_in, .meas_valid_in, .meas_temp_in,
  .reg_rdata_out, .alert_n_out, .crit_temp_n_out, .crit_temp_oe_n_out);

// ===== tb/tatm_host_proc.sv
// host processor model driving the throttle indication pin
`timescale 1ns/1ps
module tatm_host_proc (
  input wire logic clk_in,
  output logic throttle_n_out
);
  // pin is pulled up, so a released pin reads high
  initial throttle_n_out = 1'b1;

  // hold the pin asserted for n sampled cycles
  task automatic hot(input int n);
    @(posedge clk_in);
    throttle_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    throttle_n_out <= 1'b1;
  endtask : hot
endmodule : tatm_host_proc

// ===== tb/thermal_alert_throttle_monitor_tb_top.sv
// self-checking testbench of the throttle monitor
`timescale 1ns/1ps
module thermal_alert_throttle_monitor_tb_top;
  import tatm_pkg::*;
  localparam int FINE = 8;
  localparam int COARSE = 4;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] a = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] src = 7'h00;
  logic [3:0] flt = 4'h0;
  logic [3:0] en = 4'hf;
  logic [3:0] mv = 4'h0;
  logic [39:0] mt = 40'h0;
  logic thr_n;
  tatm_byte_t rdata;
  logic alert_n;
  logic crit_n;
  logic oe_n;
  int error_cnt = 0;
  int compares = 0;
  int seed = 32'h975b58d9;
  int cyc = 0;
  tatm_byte_t ra[9] = '{8'h0f, 8'h12, 8'h13, 8'h1e, 8'h1f, 8'h20, 8'h21,
    8'h22, 8'h05};
  tatm_byte_t rv[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'h64, 8'h64,
    8'h64, 8'h00};

  always #10 mclk_in = ~mclk_in;

  tatm_top #(.FINE_CYCLES(FINE), .COARSE_CYCLES(COARSE)) i_tatm_top (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_addr_in(a),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
    .cpu_throttle_n_in(thr_n), .src_out_of_limit_in(src),
    .src_fault_in(flt), .crit_chan_en_in(en), .meas_valid_in(mv),
    .meas_temp_in(mt), .reg_rdata_out(rdata), .alert_n_out(alert_n),
    .crit_temp_n_out(crit_n), .crit_temp_oe_n_out(oe_n));

  tatm_host_proc i_tatm_host_proc (.clk_in(mclk_in), .throttle_n_out(thr_n));

  task automatic chk(input tatm_byte_t got, input tatm_byte_t exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick

  task automatic wreg(input tatm_byte_t ad, input tatm_byte_t d);
    @(posedge mclk_in);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input tatm_byte_t ad, input tatm_byte_t e,
    input bit ck = 1'b1);
    @(posedge mclk_in);
    a <= ad;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    if (ck) chk(rdata, e);
  endtask : rreg

  // expected timer byte after n active cycles since the last clear
  function automatic tatm_byte_t texp(input int n);
    int v;
    if (n == 0) return 8'h00;
    if (n <= FINE) return 8'h01;
    v = 2 + (n - FINE - 1) / COARSE;
    return (v > 255) ? 8'hff : tatm_byte_t'(v);
  endfunction : texp

  task automatic hot_sync(input int n);
    i_tatm_host_proc.hot(n);
    tick(5);
  endtask : hot_sync

  task automatic meas(input int ch, input int t);
    @(posedge mclk_in);
    mv <= 4'h1 << ch;
    mt[ch*10 +: 10] <= t[9:0];
    @(posedge mclk_in);
    mv <= 4'h0;
  endtask : meas

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, the whole sequence needs under two thousand cycles
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    tatm_byte_t m;
    tatm_byte_t n;
    int s;
    int ch;
    int t;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    tick(5);
    foreach (ra[i]) rreg(ra[i], rv[i]);
    foreach (ra[i]) begin
      m = 8'($random(seed));
      wreg(ra[i], m);
      rreg(ra[i], (i == 0 || i == 8) ? 8'h00 : m);
    end
    wreg(8'h13, 8'hff);
    wreg(8'h1e, 8'h00);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      s = i % 7;
      m = (i == 0) ? 8'hff : (i == 7) ? 8'h00 : 8'($random(seed));
      wreg(8'h12, m);
      @(posedge mclk_in);
      src <= 7'h01 << s;
      tick(4);
      chk({7'h00, alert_n}, {7'h00, m[s]});
      @(posedge mclk_in);
      src <= 7'h00;
      rreg(8'h10, 8'h01 << s);
      rreg(8'h10, 8'h00);
      tick(2);
      chk({7'h00, alert_n}, 8'h01);
    end
    for (int j = 0; j < 4; j++) begin
      m = 8'($random(seed));
      n = 8'($random(seed));
      wreg(8'h12, m);
      wreg(8'h13, n);
      @(posedge mclk_in);
      flt <= 4'h1 << j;
      tick(4);
      chk({7'h00, alert_n}, {7'h00, n[j+2] | m[7]});
      @(posedge mclk_in);
      flt <= 4'h0;
      rreg(8'h10, 8'h80);
      rreg(8'h11, 8'h04 << j);
      rreg(8'h10, 8'h00);
    end
    wreg(8'h12, 8'h00);
    wreg(8'h13, 8'h00);
    $display("mask test done");
    hot_sync(3);
    rreg(8'h0f, texp(3));
    rreg(8'h11, 8'h00);
    hot_sync(10);
    hot_sync(12);
    rreg(8'h0f, texp(22));
    rreg(8'h0f, 8'h00);
    hot_sync(FINE);
    rreg(8'h0f, texp(FINE));
    hot_sync(FINE + 1);
    rreg(8'h0f, texp(FINE + 1));
    hot_sync(1100);
    rreg(8'h0f, 8'hff);
    fork
      i_tatm_host_proc.hot(12);
    join_none
    tick(6);
    rreg(8'h0f, 8'h00, 1'b0);
    tick(10);
    rreg(8'h11, 8'h02);
    rreg(8'h0f, 8'h01);
    wreg(8'h1e, 8'h01);
    hot_sync(5);
    rreg(8'h11, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    hot_sync(10);
    chk({7'h00, alert_n}, 8'h00);
    rreg(8'h11, 8'h02);
    wreg(8'h13, 8'h02);
    tick(3);
    chk({7'h00, alert_n}, 8'h01);
    rreg(8'h0f, texp(15));
    rreg(8'h11, 8'h00);
    wreg(8'h13, 8'h00);
    $display("timer test done");
    wreg(8'h02, 8'h01);
    rreg(8'h02, 8'h01);
    tick(3);
    chk({7'h00, oe_n}, 8'h00);
    for (int k = 0; k < 12; k++) begin
      ch = {$random(seed)} % 4;
      t = {$random(seed)} % 1024;
      m = 8'($random(seed));
      n = (k == 0) ? 8'hff : 8'($random(seed));
      if (k < 2) m = 8'h40;
      if (k < 2) t = 256 + 1 - k;
      // first trip lands on the channel the checker shadows
      if (k == 0) ch = 3;
      wreg(8'h1f + 8'(ch), m);
      en <= n[3:0];
      meas(ch, t);
      tick(3);
      chk({7'h00, crit_n}, {7'h00, !(n[ch] && t > 4 * m)});
      meas(ch, 0);
      tick(3);
      chk({7'h00, crit_n}, 8'h01);
    end
    rreg(8'h11, 8'h01);
    hot_sync(20);
    rreg(8'h0f, 8'h00);
    $display("crit test done");
    tally_and_finish();
  end
endmodule : thermal_alert_throttle_monitor_tb_top
